// File: bench/sms_mixer_top_props.sv
`timescale 1ns/1ps
module sms_mixer_top_props
  import sms_pkg::*;
(
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Bus.
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [DW-1:0] prdata,
  input  wire logic          pready,
  input  wire logic          pslverr,
  // Audio.
  input  wire logic          speaker_drive_first,
  input  wire logic          speaker_drive_second_oe,
  input  wire logic [OW-1:0] dac_data,
  input  wire logic          dac_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The two bus phases as seen from the slave.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready && psel && penable;
  endsequence

  a_ready_after_setup:
    assert property (s_setup |=> s_answer) else $error("no answer after setup");
  a_ready_in_access:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_single:
    assert property (pready |=> !pready) else $error("ready held too long");
  a_err_with_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_err_read_zero:
    assert property (s_answer and pslverr && !pwrite |-> prdata == '0)
      else $error("refused read not zero");
  a_modes_exclusive:
    assert property (!(dac_enable && speaker_drive_second_oe)) else $error("both outputs live");
  a_pwm_quiet_dac:
    assert property (dac_enable && $past(dac_enable) |-> !speaker_drive_first)
      else $error("pwm active in dac mode");
  // A sample update must stay put; a glitch would show as two changes close together.
  a_dac_no_glitch:
    assert property ($changed(dac_data) |=> $stable(dac_data) [*8])
      else $error("dac sample glitched");
endmodule // sms_mixer_top_props

bind sms_mixer_top sms_mixer_top_props i_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .speaker_drive_first, .speaker_drive_second_oe, .dac_data,
  .dac_enable);

// File: bench/sms_mixer_top_test.sv
`timescale 1ns/1ps
module sms_mixer_top_test
  import sms_pkg::*;
;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap = 0;
  logic [PAW-1:0] paddr  = '0;
  logic [DW-1:0]  pwdata = '0;
  logic [DW-1:0]  prdata, rd;
  logic           pready, pslverr, spk1, spk2_o, spk2_oe, spk2_i, dac_en, err;
  logic [OW-1:0]  dac_data;
  int             mismatches = 0, checked = 0;

  // Clock of 4 ns.
  always #2 pclk = ~pclk;

  // A short mixer wait keeps the run brief.
  sms_mixer_top #(.MIX_WAIT_CYCLES(20)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .speaker_drive_first(spk1),
    .speaker_drive_second_o(spk2_o), .speaker_drive_second_oe(spk2_oe),
    .speaker_drive_second_i(spk2_i), .dac_data, .dac_enable(dac_en));
  sms_pad_model i_pad (.pad_o(spk2_o), .pad_oe(spk2_oe), .strap_high(strap), .pad_level(spk2_i));

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the edge at entry keeps psel from being set twice in one step.
  task automatic apb(input logic w, input logic [PAW-1:0] a, input logic [DW-1:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_status(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, '0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // Reset with the pad strapped; the select bit must follow the pad.
  task automatic t_strap(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_status(ST_INIT);
    apb(1'b0, REG_GLOBAL, '0); // Select is read, never written, while the pad decides.
    chk(rd, {24'h0, VOL_RST, 2'h0, s, 1'b0});
    repeat (4) @(posedge pclk);
    chk({spk2_oe, dac_en}, {!s, s});
  endtask

  // An unmapped place refuses both directions and reads zero.
  task automatic t_unmapped();
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, 12'h020, '0);
    chk(rd, '0);
    chk(err, 1'b1);
  endtask

  // Plays one word on n looping channels in DAC mode and checks the scaled sample.
  // With a set the word holds two compressed +7 codes; the predictor then climbs
  // into saturation at the 10-bit maximum, so s must be that maximum.
  task automatic t_play(input int n, input int s, input int e, input int v, input int a = 0);
    int t;
    t = (n * s * e) >>> 8;
    t = (t * (v + 1)) >>> 4;
    if (t > 2047) t = 2047;
    if (t < -2048) t = -2048;
    apb(1'b1, REG_MADDR, '0);
    apb(1'b1, REG_MDATA, a ? 32'h0e7 : DW'(s) & 32'h3ff);
    for (int c = 0; c < n; c++) begin
      apb(1'b1, PAW'(CH_BASE + 16 * c),
          DW'(((a ? FORM_HEAD_TAIL : FORM_TAIL) << CFG_FORM_LSB) | (e << CFG_ENVELOPE_LOW_NIBBLE_LSB) |
              (a << CFG_ADPCM)));
      for (int k = 1; k < 4; k++) begin
        apb(1'b1, PAW'(CH_BASE + 16 * c + 4 * k), '0);
      end
    end
    apb(1'b1, REG_GLOBAL, {24'h0, 4'(v), 2'h0, OUT_SEL_DAC, 1'b1});
    wait_status(ST_READY);
    apb(1'b1, REG_PLAY, DW'(32'h3f00 | ((1 << n) - 1)));
    repeat (a ? 600 : 200) @(posedge pclk);
    chk(dac_data, DW'(t + 2048));
    chk({spk1, dac_en}, 2'b01);
  endtask

  // Switch the live sample 0x880 to PWM and count both phases over one full period.
  task automatic t_pwm();
    int h1, h2;
    apb(1'b1, REG_GLOBAL, {24'h0, 4'hf, 2'h0, OUT_SEL_PWM, 1'b1});
    repeat (4200) @(posedge pclk);
    h1 = 0;
    h2 = 0;
    repeat (4096) begin
      @(posedge pclk);
      h1 += spk1;
      h2 += spk2_o;
    end
    chk(DW'(h1), 32'h880);
    chk(DW'(h2), 32'h77f);
    chk({spk2_oe, dac_en}, 2'b10);
  endtask

  // A patch that plays once, or a loop with release set, stops at its end in silence.
  task automatic t_stop(input logic [DW-1:0] cfg);
    apb(1'b1, CH_BASE, cfg | 32'hff00);
    apb(1'b1, REG_PLAY, 32'h1);
    repeat (200) @(posedge pclk);
    apb(1'b0, REG_STATUS, '0);
    chk(rd[NCH-1:0], '0);
    chk(dac_data, 32'h800);
  endtask

  // Main sequence.
  initial begin
    t_strap(1'b0);
    t_strap(1'b1);
    t_unmapped();
    apb(1'b1, REG_PERIOD, 32'd40);
    t_play(6, 511, 255, 15);
    t_play(6, -512, 255, 15);
    t_play(1, 256, 'h5a, 0);
    t_play(1, 256, 128, 7);
    t_play(1, 511, 255, 15, 1);
    t_play(1, 256, 128, 15);
    t_pwm();
    t_stop(DW'(FORM_ONCE) << CFG_FORM_LSB);
    t_stop((DW'(FORM_TAIL) << CFG_FORM_LSB) | (DW'(1) << CFG_RELEASE));
    tally_and_finish();
  end
endmodule // sms_mixer_top_test

// File: bench/sms_pad_model.sv
`timescale 1ns/1ps
module sms_pad_model (
  // Drive from the block.
  input  wire logic pad_o,
  input  wire logic pad_oe,
  // Board strap: 1 ties the pad high, 0 leaves it floating.
  input  wire logic strap_high,
  // Level seen back at the pad.
  output logic      pad_level
);
  // A floating pad settles low through its pull-down, never to the last level.
  assign pad_level = pad_oe ? pad_o : strap_high;
endmodule // sms_pad_model

// File: rtl/sms_mixer_top.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module sms_mixer_top
  import sms_pkg::*;
#(
  parameter int unsigned MIX_WAIT_CYCLES = MIX_WAIT_CYC
)(
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic [PAW-1:0]  paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [DW-1:0]   pwdata,
  output logic      [DW-1:0]   prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Speaker and DAC outputs.
  output logic                 speaker_drive_first,
  output logic                 speaker_drive_second_o,
  output logic                 speaker_drive_second_oe,
  input  wire logic            speaker_drive_second_i,
  output logic      [OW-1:0]   dac_data,
  output logic                 dac_enable
);

  localparam int WCW = $clog2(MIX_WAIT_CYCLES + 1);

  // Global control and status state.
  logic                 mix_en_r;
  logic                 audio_output_select_r;
  logic [VOLW-1:0]      master_volume_level_r;
  logic [PERW-1:0]      period_r;
  logic [AW-1:0]        maddr_r;
  logic [WCW-1:0]       wait_cnt_r;
  logic                 mix_ready_r;
  logic [1:0]           strap_sync_r;
  logic [2:0]           strap_cnt_r;
  logic                 init_done_r;
  // Channel configuration.
  logic [CFGW-1:0]      cfg_r   [NCH];
  logic [AW-1:0]        start_r [NCH];
  logic [AW-1:0]        loop_r  [NCH];
  logic [AW-1:0]        end_r   [NCH];
  // Channel play state.
  logic [NCH-1:0]       active_r;
  logic [NCH-1:0]       half_r;
  logic [AW-1:0]        pos_r   [NCH];
  logic signed [SW-1:0] pred_r  [NCH];
  logic [SHW-1:0]       shift_r [NCH];
  // Sequencer and output state.
  sms_seq_e             state_r;
  logic [CHW-1:0]       ch_r;
  logic [PERW-1:0]      tick_cnt_r;
  logic signed [ACCW-1:0] acc_r;
  logic [OW-1:0]        sample_r;
  logic                 sel_live_r;
  logic [OW-1:0]        pwm_cnt_r;
  logic [OW-1:0]        pwm_level_r;
  logic [SW-1:0]        mem_rdata;

  // Bus phase decode; writes commit in the access cycle, which always completes at once.
  wire                  setup_ph  = psel & ~penable;
  wire                  wr_en     = psel & penable & pready & pwrite;
  wire [PAW-1:0]        ch_off    = paddr - CH_BASE;
  wire [CHW-1:0]        ch_idx    = ch_off[CH_HI_LSB-1:CH_IDX_LSB];
  wire [1:0]            ch_fld    = paddr[3:2];
  wire                  ch_hit    = (paddr >= CH_BASE) && (ch_off[PAW-1:CH_HI_LSB] == '0) &&
                                    (32'(ch_idx) < NCH) && (paddr[1:0] == 2'h0);
  wire                  wr_global = wr_en & (paddr == REG_GLOBAL);
  wire                  wr_mdata  = wr_en & (paddr == REG_MDATA);
  wire                  wr_play   = wr_en & (paddr == REG_PLAY);
  wire [NCH-1:0]        start_pls = wr_play ? pwdata[NCH-1:0] : '0;
  wire [NCH-1:0]        stop_pls  = wr_play ? pwdata[PLAY_STOP_LSB +: NCH] : '0;

  // Current-channel decode for the word the memory just returned.
  wire [CFGW-1:0]       cur_cfg   = cfg_r[ch_r];
  wire                  cur_adpcm = cur_cfg[CFG_ADPCM];
  wire [1:0]            cur_form  = cur_cfg[CFG_FORM_LSB +: 2];
  wire [CODEW-1:0]      code      = half_r[ch_r] ? mem_rdata[SW-1:CODEW] : mem_rdata[CODEW-1:0];
  wire [NIBW-1:0]       nib       = code[NIBW-1:0];
  wire [NIBW-1:0]       mag       = nib[NIBW-1] ? NIBW'(-nib) : nib;
  wire [SHW-1:0]        sh        = shift_r[ch_r] + (code[NIBW] ? ADPCM_COARSE : '0);
  wire signed [SATW-1:0] delta    = $signed({{(SATW-NIBW){nib[NIBW-1]}}, nib}) <<< sh;
  wire signed [SATW-1:0] pred_ext = {{(SATW-SW){pred_r[ch_r][SW-1]}}, pred_r[ch_r]};
  wire signed [SATW-1:0] adp_sum  = sms_sat(pred_ext + delta, SW);
  wire signed [SW-1:0]  new_smp   = cur_adpcm ? adp_sum[SW-1:0] : mem_rdata;
  wire [ENVW-1:0]       env       = {cur_cfg[CFG_ENVELOPE_HIGH_NIBBLE_LSB +: 4], cur_cfg[CFG_ENVELOPE_LOW_NIBBLE_LSB +: 4]};
  wire signed [SATW-1:0] product  = $signed({{(SATW-SW){new_smp[SW-1]}}, new_smp}) *
                                    $signed({{(SATW-ENVW){1'b0}}, env});
  wire                  step_word = ~cur_adpcm | half_r[ch_r];
  wire                  at_end    = pos_r[ch_r] == end_r[ch_r];
  wire                  finishes  = step_word & at_end &
                                    ((cur_form == FORM_ONCE) | cur_cfg[CFG_RELEASE]);
  wire [AW-1:0]         pos_nxt   = ~step_word ? pos_r[ch_r] :
                                    (at_end ? loop_r[ch_r] : pos_r[ch_r] + AW'(1));
  wire                  decode_we = (state_r == SEQ_DECODE) & active_r[ch_r];

  // Final volume stage and saturation of the mixed sum.
  wire signed [ACCW-1:0] mixed    = acc_r >>> ENV_SH;
  wire [VOLW:0]         vol_mul   = {1'b0, master_volume_level_r} + (VOLW+1)'(1);
  wire signed [ACCW-1:0] scaled   = (mixed * $signed({{(ACCW-VOLW-1){1'b0}}, vol_mul})) >>> VOL_SH;
  wire signed [SATW-1:0] final_s  = sms_sat(scaled[SATW-1:0], OW);
  wire [OW-1:0]         final_u   = {~final_s[OW-1], final_s[OW-2:0]};
  wire                  tick      = (tick_cnt_r >= period_r - PERW'(1));

  // Read data multiplexer; unmapped offsets read as zero and report an error.
  logic [DW-1:0] rdata_nxt;
  logic          mapped;
  always_comb begin
    rdata_nxt = '0;
    mapped    = 1'b1;
    if (ch_hit) begin
      unique case (ch_fld)
        CH_CFG:   rdata_nxt = DW'(cfg_r[ch_idx]);
        CH_START: rdata_nxt = DW'(start_r[ch_idx]);
        CH_LOOP:  rdata_nxt = DW'(loop_r[ch_idx]);
        CH_END:   rdata_nxt = DW'(end_r[ch_idx]);
      endcase
    end else begin
      case (paddr)
        REG_GLOBAL: rdata_nxt = DW'({master_volume_level_r, 2'b00,
                                    audio_output_select_r, mix_en_r});
        REG_PERIOD: rdata_nxt = DW'(period_r);
        REG_MADDR:  rdata_nxt = DW'(maddr_r);
        REG_MDATA:  rdata_nxt = '0;
        REG_PLAY:   rdata_nxt = DW'(active_r);
        REG_STATUS: rdata_nxt = DW'({init_done_r, mix_ready_r, 2'b00, active_r});
        default:    mapped    = 1'b0;
      endcase
    end
  end

  // Bus answer is prepared in the setup cycle so every bus output is a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= setup_ph ? rdata_nxt : prdata;
      pslverr <= setup_ph & ~mapped;
    end
  end

  // Global registers; the select bit is preset once from the sensed pad after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_en_r              <= 1'b0;
      audio_output_select_r <= OUT_SEL_DAC;
      master_volume_level_r <= VOL_RST;
      period_r              <= PERIOD_RST;
      maddr_r               <= '0;
      strap_sync_r          <= 2'b00;
      strap_cnt_r           <= '0;
      init_done_r           <= 1'b0;
    end else begin
      strap_sync_r <= {strap_sync_r[0], speaker_drive_second_i};
      if (!init_done_r) begin
        strap_cnt_r <= strap_cnt_r + 3'h1;
        if (strap_cnt_r == STRAP_SETTLE) begin
          audio_output_select_r <= strap_sync_r[1] ? OUT_SEL_DAC : OUT_SEL_PWM;
          init_done_r           <= 1'b1;
        end
      end
      if (wr_global) begin
        mix_en_r              <= pwdata[G_MIX_EN];
        audio_output_select_r <= pwdata[G_OUT_SEL];
        master_volume_level_r <= pwdata[G_VOL_LSB +: VOLW];
      end
      if (wr_en && paddr == REG_PERIOD) period_r <= pwdata[PERW-1:0];
      if (wr_en && paddr == REG_MADDR) maddr_r <= pwdata[AW-1:0];
      else if (wr_mdata) maddr_r <= maddr_r + AW'(1);
    end
  end

  // Ready flag shows when the mixer has settled long enough for the first play.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_r  <= '0;
      mix_ready_r <= 1'b0;
    end else if (!mix_en_r) begin
      wait_cnt_r  <= '0;
      mix_ready_r <= 1'b0;
    end else if (!mix_ready_r) begin
      wait_cnt_r  <= wait_cnt_r + WCW'(1);
      mix_ready_r <= (wait_cnt_r == WCW'(MIX_WAIT_CYCLES - 1));
    end
  end

  // Channel configuration written by software; envelope nibbles may change during play.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c]   <= '0;
        start_r[c] <= '0;
        loop_r[c]  <= '0;
        end_r[c]   <= '0;
      end
    end else if (wr_en && ch_hit) begin
      unique case (ch_fld)
        CH_CFG:   cfg_r[ch_idx]   <= pwdata[CFGW-1:0];
        CH_START: start_r[ch_idx] <= pwdata[AW-1:0];
        CH_LOOP:  loop_r[ch_idx]  <= pwdata[AW-1:0];
        CH_END:   end_r[ch_idx]   <= pwdata[AW-1:0];
      endcase
    end
  end

  // Per-channel play state; a play command wins over a stop and over the sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= '0;
      half_r   <= '0;
      for (int c = 0; c < NCH; c++) begin
        pos_r[c]   <= '0;
        pred_r[c]  <= '0;
        shift_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (start_pls[c]) begin
          active_r[c] <= 1'b1;
          half_r[c]   <= 1'b0;
          pos_r[c]    <= (cfg_r[c][CFG_FORM_LSB +: 2] == FORM_TAIL) ? loop_r[c] : start_r[c];
          pred_r[c]   <= '0;
          shift_r[c]  <= '0;
        end else if (stop_pls[c]) begin
          active_r[c] <= 1'b0;
        end else if (decode_we && 32'(ch_r) == c) begin
          active_r[c] <= ~finishes;
          pos_r[c]    <= pos_nxt;
          half_r[c]   <= cur_adpcm & ~half_r[c];
          pred_r[c]   <= new_smp;
          if (cur_adpcm && mag >= GROW_MAG && shift_r[c] < SHIFT_MAX) begin
            shift_r[c] <= shift_r[c] + SHW'(1);
          end else if (cur_adpcm && mag <= SHRINK_MAG && shift_r[c] != '0) begin
            shift_r[c] <= shift_r[c] - SHW'(1);
          end
        end
      end
    end
  end

  // Sequencer visits the six channels once per output sample through one memory port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= SEQ_IDLE;
      ch_r       <= '0;
      tick_cnt_r <= '0;
      acc_r      <= '0;
      sample_r   <= {1'b1, {(OW-1){1'b0}}};
      sel_live_r <= OUT_SEL_DAC;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + PERW'(1);
      unique case (state_r)
        SEQ_IDLE: begin
          if (!mix_en_r) sel_live_r <= audio_output_select_r;
          if (tick && mix_en_r) begin
            ch_r    <= '0;
            acc_r   <= '0;
            state_r <= SEQ_READ;
          end
        end
        SEQ_READ: state_r <= SEQ_DECODE;
        SEQ_DECODE: begin
          if (active_r[ch_r]) acc_r <= acc_r + ACCW'(product);
          if (32'(ch_r) == NCH - 1) begin
            state_r <= SEQ_FINISH;
          end else begin
            ch_r    <= ch_r + CHW'(1);
            state_r <= SEQ_READ;
          end
        end
        SEQ_FINISH: begin
          sample_r   <= final_u;
          sel_live_r <= audio_output_select_r;
          state_r    <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Output stage; the PWM level reloads only at the period wrap so no pulse is cut short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_r               <= '0;
      pwm_level_r             <= {1'b1, {(OW-1){1'b0}}};
      speaker_drive_first     <= 1'b0;
      speaker_drive_second_o  <= 1'b0;
      speaker_drive_second_oe <= 1'b0;
      dac_data                <= {1'b1, {(OW-1){1'b0}}};
      dac_enable              <= 1'b0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + OW'(1);
      if (pwm_cnt_r == '1) pwm_level_r <= sample_r;
      speaker_drive_first     <= (sel_live_r == OUT_SEL_PWM) & (pwm_cnt_r < pwm_level_r);
      speaker_drive_second_o  <= (sel_live_r == OUT_SEL_PWM) & (pwm_cnt_r < ~pwm_level_r);
      speaker_drive_second_oe <= init_done_r & (sel_live_r == OUT_SEL_PWM);
      dac_data                <= sample_r;
      dac_enable              <= init_done_r & (sel_live_r == OUT_SEL_DAC);
    end
  end

  sms_sample_mem u_mem (
    .pclk    (pclk),
    .wr_en   (wr_mdata),
    .wr_addr (maddr_r),
    .wr_data (pwdata[SW-1:0]),
    .rd_en   (state_r == SEQ_READ),
    .rd_addr (pos_r[ch_r]),
    .rd_data (mem_rdata)
  );

endmodule // sms_mixer_top

// File: rtl/sms_sample_mem.sv
`timescale 1ns/1ps
module sms_sample_mem
  import sms_pkg::*;
(
  // Clock.
  input  wire logic          pclk,
  // Write port.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [SW-1:0] wr_data,
  // Read port.
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [SW-1:0] rd_data
);

  logic [SW-1:0] mem_r [2**AW];

  // Contents are undefined until software loads them, so no reset is spent on the array.
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // sms_sample_mem

// File: shared/sms_pkg.sv
package sms_pkg;

  // Structure of the synthesizer datapath.
  localparam int NCH    = 6;   // Synthesis channels.
  localparam int AW     = 10;  // Sample memory address width.
  localparam int SW     = 10;  // Decoded sample width.
  localparam int CODEW  = 5;   // Compressed code width, two codes to a word.
  localparam int NIBW   = 4;   // Signed delta part of a compressed code.
  localparam int OW     = 12;  // Output sample width.
  localparam int ENVW   = 8;   // Envelope width.
  localparam int VOLW   = 4;   // Master volume width.
  localparam int ACCW   = 22;  // Mixer accumulator width.
  localparam int SATW   = 20;  // Working width of saturating arithmetic.
  localparam int CHW    = 3;   // Channel index width.
  localparam int PERW   = 16;  // Sample period counter width.
  localparam int SHW    = 4;   // Delta shift width.
  localparam int DW     = 32;  // Bus data width.
  localparam int PAW    = 12;  // Bus address width.

  // Register byte offsets.
  localparam logic [PAW-1:0] REG_GLOBAL = 12'h000;
  localparam logic [PAW-1:0] REG_PERIOD = 12'h004;
  localparam logic [PAW-1:0] REG_MADDR  = 12'h008;
  localparam logic [PAW-1:0] REG_MDATA  = 12'h00c;
  localparam logic [PAW-1:0] REG_PLAY   = 12'h010;
  localparam logic [PAW-1:0] REG_STATUS = 12'h014;
  localparam logic [PAW-1:0] CH_BASE    = 12'h040;
  localparam int             CH_IDX_LSB = 4;
  localparam int             CH_HI_LSB  = 7;
  localparam logic [1:0]     CH_CFG     = 2'h0;
  localparam logic [1:0]     CH_START   = 2'h1;
  localparam logic [1:0]     CH_LOOP    = 2'h2;
  localparam logic [1:0]     CH_END     = 2'h3;

  // Field positions.
  localparam int G_MIX_EN     = 0;
  localparam int G_OUT_SEL    = 1;
  localparam int G_VOL_LSB    = 4;
  localparam int CFG_ADPCM    = 0;
  localparam int CFG_FORM_LSB = 1;
  localparam int CFG_RELEASE  = 3;
  localparam int CFG_ENVELOPE_LOW_NIBBLE_LSB = 8;
  localparam int CFG_ENVELOPE_HIGH_NIBBLE_LSB = 12;
  localparam int CFGW         = 16;
  localparam int PLAY_STOP_LSB = 8;
  localparam int ST_READY     = 8;
  localparam int ST_INIT      = 9;

  // Patch forms.
  localparam logic [1:0] FORM_ONCE      = 2'h0;
  localparam logic [1:0] FORM_HEAD_TAIL = 2'h1;
  localparam logic [1:0] FORM_TAIL      = 2'h2;

  // Output select codes.
  localparam logic OUT_SEL_PWM = 1'b0;
  localparam logic OUT_SEL_DAC = 1'b1;

  // Reset values and arithmetic constants.
  localparam logic [PERW-1:0] PERIOD_RST   = 16'h1625;
  localparam logic [VOLW-1:0] VOL_RST      = 4'hf;
  localparam logic [SHW-1:0]  ADPCM_COARSE = 4'h2;
  localparam logic [SHW-1:0]  SHIFT_MAX    = 4'h6;
  localparam logic [NIBW-1:0] GROW_MAG     = 4'h6;
  localparam logic [NIBW-1:0] SHRINK_MAG   = 4'h1;
  localparam int              ENV_SH       = 8;
  localparam int              VOL_SH       = 4;
  localparam logic [2:0]      STRAP_SETTLE = 3'h4;

  // Settling time the controller must leave after enabling the mixer.
  localparam int MIX_WAIT_NS   = 40000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIX_WAIT_CYC  = (MIX_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_READ   = 2'b01,
    SEQ_DECODE = 2'b11,
    SEQ_FINISH = 2'b10
  } sms_seq_e;

  // Clamps a signed value into a signed range of the given width.
  function automatic logic signed [SATW-1:0] sms_sat(input logic signed [SATW-1:0] v,
                                                     input int unsigned bits);
    logic signed [SATW-1:0] hi;
    hi = $signed(SATW'((1 << (bits - 1)) - 1));
    if (v > hi) return hi;
    if (v < ~hi) return ~hi;
    return v;
  endfunction

endpackage
